// ===== mrs_pkg.sv
// constants, field layout and codes for the micromachine register set
// assumes one 125 MHz clock where each rising clock edge closes one microcycle
package mrs_pkg;
  // microinstruction field positions
  localparam int WORD_W  = 32;
  localparam int WT_HI   = 31;
  localparam int WT_LO   = 28;
  localparam int SPC_HI  = 27;
  localparam int SPC_LO  = 24;
  localparam int BF_HI   = 23;
  localparam int BF_LO   = 19;
  localparam int STF_HI  = 18;
  localparam int STF_LO  = 14;
  localparam int ALU_HI  = 13;
  localparam int ALU_LO  = 10;
  localparam int JA_HI   = 27;
  localparam int JA_LO   = 14;
  localparam int IMM_HI  = 15;
  localparam int IMM_LO  = 0;
  localparam int UA_W    = 14;
  localparam int STK_W   = 3;
  localparam int STK_N   = 8;
  localparam int DW      = 16;
  localparam int IDX_W   = 4;
  localparam int FILE_N  = 16;
  localparam int MAP_ADDRESS_POINTER_W  = 10;
  localparam int PEA_W   = 24;
  localparam int INT_N   = 4;
  localparam int SW_SELFTEST_LO = 11;

  // eleven word types; other encodings execute as no-operation
  typedef enum logic [3:0] {
    WT_ALU  = 4'h0, WT_JMP  = 4'h1, WT_JSB  = 4'h2, WT_RTN = 4'h3,
    WT_JZ   = 4'h4, WT_JNZ  = 4'h5, WT_JINT = 4'h6, WT_JSW = 4'h7,
    WT_IMM  = 4'h8, WT_NOP  = 4'h9, WT_SPEC = 4'hA
  } mrs_wtype_e;

  typedef enum logic [3:0] {
    SPC_NONE = 4'h0, SPC_ZERO = 4'h1, SPC_ONE = 4'h2, SPC_INCP = 4'h3,
    SPC_INCN = 4'h4, SPC_DECN = 4'h5, SPC_INTCLR = 4'h6
  } mrs_spec_e;

  typedef enum logic [4:0] {
    B_ZERO = 5'h00, B_P   = 5'h01, B_Q   = 5'h02, B_T   = 5'h03, B_SW  = 5'h04, B_N = 5'h05,
    B_SCR  = 5'h06, B_PRV = 5'h07, B_EXT = 5'h08, B_MAP = 5'h09, B_ACC = 5'h0A, B_INT = 5'h0B
  } mrs_bsel_e;

  typedef enum logic [4:0] {
    S_NONE = 5'h00, S_P = 5'h01, S_ACC = 5'h02, S_N = 5'h03,
    S_SCR  = 5'h04, S_PRV = 5'h05, S_EXT = 5'h06, S_MAP = 5'h07
  } mrs_store_field_e;

  typedef enum logic [3:0] {
    ALU_PASS = 4'h0, ALU_ADD = 4'h1, ALU_SUB = 4'h2, ALU_AND = 4'h3, ALU_OR = 4'h4,
    ALU_XOR  = 4'h5, ALU_INC = 4'h6, ALU_DSHL = 4'h7, ALU_DSHR = 4'h8
  } mrs_alu_e;

  // external special register indices
  localparam logic [3:0] EXT_MAP_ADDRESS_POINTER   = 4'h0;
  localparam logic [3:0] EXT_PEL_LO = 4'h1;
  localparam logic [3:0] EXT_PEL_HI = 4'h2;
  localparam logic [3:0] EXT_CIL    = 4'h3;
  localparam logic [1:0] EXT_FPA_HI = 2'h3;

  // interrupt codes, internal sources rank above the I/O source
  localparam logic [2:0] INT_NONE = 3'h0;
  localparam logic [2:0] INT_IO   = 3'h1;
  localparam logic [2:0] INT_BASE = 3'h2;

  localparam logic [UA_W-1:0]  UA_RESET  = 14'h0000;
  localparam logic [UA_W-1:0]  UA_ONE    = 14'h0001;
  localparam logic [DW-1:0]    D_ZERO    = 16'h0000;
  localparam logic [DW-1:0]    D_ONE     = 16'h0001;
  localparam logic [MAP_ADDRESS_POINTER_W-1:0] MAP_ADDRESS_POINTER_ONE = 10'h001;
  localparam logic [IDX_W-1:0] IDX_ONE   = 4'h1;
  localparam logic [STK_W-1:0] STK_ONE   = 3'h1;
endpackage

// ===== mrs_register_set.sv
// micromachine register set with sequencer, stack and external special registers
// assumes control store returns the word for cs_addr in the same cycle; inputs synchronous
`timescale 1ns/1ns

// What this block does
// - program counter increments on its microorder unless the same word stores it
// - low word loads on both special codes and in double shifts
// - low word is lower half in double shifts
// - low word muxed into ALU, not bus
// - switch register presents panel switch fields
// - memory return loads only from returned data
// - sixteen scratch registers indexed by index register
// - sixteen privileged registers indexed by index register
// - external register chosen by whole four-bit index
// - map pointer ten bits, upper bits zero
// - every map access increments map pointer unless the same word writes the pointer
// - low parity latch holds low address
// - parity latches update on every error
// - high parity latch holds upper byte only
// - index three holds last trap cell
// - indices four-B reserved, C-F go accessory
// - microinstruction is 32 bits of fields
// - decoder knows eleven word types
// - destination clocked at microcycle end
// - call pushes address plus one, return pops
// - interrupts latched, internal above I/O
// - always sequencing from control store
// - index register four bits addresses files
module mrs_register_set (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  output logic [mrs_pkg::UA_W-1:0]       cs_addr,
  input  wire logic [mrs_pkg::WORD_W-1:0] cs_word,
  input  wire logic [mrs_pkg::DW-1:0]    switches,
  input  wire logic                      mem_ret_valid,
  input  wire logic [mrs_pkg::DW-1:0]    mem_ret_data,
  input  wire logic                      pe_strobe,
  input  wire logic [mrs_pkg::PEA_W-1:0] pe_addr,
  input  wire logic                      io_int_strobe,
  input  wire logic [mrs_pkg::DW-1:0]    io_trap_cell,
  input  wire logic [mrs_pkg::INT_N-1:0] int_internal,
  output logic [mrs_pkg::MAP_ADDRESS_POINTER_W-1:0]     map_addr,
  output logic                           map_rd,
  input  wire logic [mrs_pkg::DW-1:0]    map_rdata,
  output logic                           map_wr,
  output logic [mrs_pkg::MAP_ADDRESS_POINTER_W-1:0]     map_waddr,
  output logic [mrs_pkg::DW-1:0]         map_wdata,
  output logic [mrs_pkg::IDX_W-1:0]      fpa_index,
  output logic                           fpa_rd,
  input  wire logic [mrs_pkg::DW-1:0]    fpa_rdata,
  output logic                           fpa_wr,
  output logic [mrs_pkg::IDX_W-1:0]      fpa_windex,
  output logic [mrs_pkg::DW-1:0]         fpa_wdata,
  output logic [mrs_pkg::DW-1:0]         pc_out,
  output logic [mrs_pkg::DW-1:0]         acc_out,
  output logic [mrs_pkg::DW-1:0]         low_word_out,
  output logic                           int_pending,
  output logic [2:0]                     int_code,
  output logic                           diag_mode
);

  logic [mrs_pkg::UA_W-1:0]   upc_reg;
  logic [mrs_pkg::UA_W-1:0]   upc_next;
  logic [mrs_pkg::UA_W-1:0]   stk_mem [mrs_pkg::STK_N];
  logic [mrs_pkg::STK_W-1:0]  sp_reg;
  logic [mrs_pkg::UA_W-1:0]   stk_top;
  logic [mrs_pkg::DW-1:0]     p_reg;
  logic [mrs_pkg::DW-1:0]     q_reg;
  logic [mrs_pkg::DW-1:0]     t_reg;
  logic [mrs_pkg::DW-1:0]     sw_reg;
  logic [mrs_pkg::DW-1:0]     acc_reg;
  logic [mrs_pkg::IDX_W-1:0]  n_reg;
  logic [mrs_pkg::DW-1:0]     scr_mem [mrs_pkg::FILE_N];
  logic [mrs_pkg::DW-1:0]     prv_mem [mrs_pkg::FILE_N];
  logic [mrs_pkg::MAP_ADDRESS_POINTER_W-1:0] map_address_pointer_reg;
  logic [mrs_pkg::DW-1:0]     pel_lo_reg;
  logic [7:0]                 pel_hi_reg;
  logic [mrs_pkg::DW-1:0]     cil_reg;
  logic [mrs_pkg::INT_N:0]    ipend_reg;
  logic                       zero_reg;
  logic [mrs_pkg::DW-1:0]     bmux;
  logic [mrs_pkg::DW-1:0]     ext_rd;
  logic [mrs_pkg::DW-1:0]     alu_y;
  logic [mrs_pkg::DW-1:0]     alu_q;
  logic                       alu_dbl;
  logic                       is_alu;
  logic                       fpa_sel;
  logic                       load_low_word;
  logic                       map_acc;
  logic                       map_address_pointer_wr;
  logic [mrs_pkg::INT_N:0]    iclr;
  logic                       ext_rd_hi_ok;

  mrs_pkg::mrs_wtype_e wt;
  mrs_pkg::mrs_spec_e  spc;
  mrs_pkg::mrs_bsel_e  bsel;
  mrs_pkg::mrs_store_field_e  store_field;
  mrs_pkg::mrs_alu_e   aop;

  // field decode of the 32-bit word
  assign wt      = mrs_pkg::mrs_wtype_e'(cs_word[mrs_pkg::WT_HI:mrs_pkg::WT_LO]);
  assign spc     = mrs_pkg::mrs_spec_e'(cs_word[mrs_pkg::SPC_HI:mrs_pkg::SPC_LO]);
  assign bsel    = mrs_pkg::mrs_bsel_e'(cs_word[mrs_pkg::BF_HI:mrs_pkg::BF_LO]);
  assign store_field    = mrs_pkg::mrs_store_field_e'(cs_word[mrs_pkg::STF_HI:mrs_pkg::STF_LO]);
  assign aop     = mrs_pkg::mrs_alu_e'(cs_word[mrs_pkg::ALU_HI:mrs_pkg::ALU_LO]);
  assign is_alu  = (wt == mrs_pkg::WT_ALU);
  assign fpa_sel = (n_reg[3:2] == mrs_pkg::EXT_FPA_HI);
  assign load_low_word     = is_alu && (spc == mrs_pkg::SPC_ZERO || spc == mrs_pkg::SPC_ONE);
  assign map_acc = is_alu && (bsel == mrs_pkg::B_MAP || store_field == mrs_pkg::S_MAP);
  assign map_address_pointer_wr = is_alu && store_field == mrs_pkg::S_EXT && n_reg == mrs_pkg::EXT_MAP_ADDRESS_POINTER;
  assign stk_top = stk_mem[sp_reg - mrs_pkg::STK_ONE];

  // external special register read, selected by the whole four-bit index
  always_comb begin
    case (n_reg)
      mrs_pkg::EXT_MAP_ADDRESS_POINTER:   ext_rd = {6'h00, map_address_pointer_reg};
      mrs_pkg::EXT_PEL_LO: ext_rd = pel_lo_reg;
      mrs_pkg::EXT_PEL_HI: ext_rd = {8'h00, pel_hi_reg};
      mrs_pkg::EXT_CIL:    ext_rd = cil_reg;
      default:             ext_rd = fpa_sel ? fpa_rdata : mrs_pkg::D_ZERO;
    endcase
  end

  // B operand; low word joins here rather than on the bus
  always_comb begin
    case (bsel)
      mrs_pkg::B_P:   bmux = p_reg;
      mrs_pkg::B_Q:   bmux = q_reg;
      mrs_pkg::B_T:   bmux = t_reg;
      mrs_pkg::B_SW:  bmux = sw_reg;
      mrs_pkg::B_N:   bmux = {12'h000, n_reg};
      mrs_pkg::B_SCR: bmux = scr_mem[n_reg];
      mrs_pkg::B_PRV: bmux = prv_mem[n_reg];
      mrs_pkg::B_EXT: bmux = ext_rd;
      mrs_pkg::B_MAP: bmux = map_rdata;
      mrs_pkg::B_ACC: bmux = acc_reg;
      mrs_pkg::B_INT: bmux = {13'h0000, int_code};
      default:        bmux = mrs_pkg::D_ZERO;
    endcase
  end

  always_comb begin
    alu_q   = q_reg;
    alu_dbl = 1'b0;
    case (aop)
      mrs_pkg::ALU_PASS: alu_y = bmux;
      mrs_pkg::ALU_ADD:  alu_y = acc_reg + bmux;
      mrs_pkg::ALU_SUB:  alu_y = acc_reg - bmux;
      mrs_pkg::ALU_AND:  alu_y = acc_reg & bmux;
      mrs_pkg::ALU_OR:   alu_y = acc_reg | bmux;
      mrs_pkg::ALU_XOR:  alu_y = acc_reg ^ bmux;
      mrs_pkg::ALU_INC:  alu_y = bmux + mrs_pkg::D_ONE;
      mrs_pkg::ALU_DSHL: begin
        {alu_y, alu_q} = {bmux[14:0], q_reg, 1'b0};
        alu_dbl = 1'b1;
      end
      mrs_pkg::ALU_DSHR: begin
        {alu_y, alu_q} = {1'b0, bmux, q_reg[15:1]};
        alu_dbl = 1'b1;
      end
      default:           alu_y = bmux;
    endcase
  end

  // sequencer: every cycle fetches a new word, no idle state
  always_comb begin
    upc_next = upc_reg + mrs_pkg::UA_ONE;
    case (wt)
      mrs_pkg::WT_JMP, mrs_pkg::WT_JSB: upc_next = cs_word[mrs_pkg::JA_HI:mrs_pkg::JA_LO];
      mrs_pkg::WT_RTN:  upc_next = stk_top;
      mrs_pkg::WT_JZ:   if (zero_reg) upc_next = cs_word[mrs_pkg::JA_HI:mrs_pkg::JA_LO];
      mrs_pkg::WT_JNZ:  if (!zero_reg) upc_next = cs_word[mrs_pkg::JA_HI:mrs_pkg::JA_LO];
      mrs_pkg::WT_JINT: if (int_pending) upc_next = cs_word[mrs_pkg::JA_HI:mrs_pkg::JA_LO];
      mrs_pkg::WT_JSW:  if (diag_mode) upc_next = cs_word[mrs_pkg::JA_HI:mrs_pkg::JA_LO];
      default:          upc_next = upc_reg + mrs_pkg::UA_ONE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) upc_reg <= mrs_pkg::UA_RESET;
    else     upc_reg <= upc_next;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sp_reg <= '0;
    end else if (wt == mrs_pkg::WT_JSB) begin
      stk_mem[sp_reg] <= upc_reg + mrs_pkg::UA_ONE;
      sp_reg          <= sp_reg + mrs_pkg::STK_ONE;
    end else if (wt == mrs_pkg::WT_RTN) begin
      sp_reg <= sp_reg - mrs_pkg::STK_ONE;
    end
  end

  // destinations take the result at the closing edge
  always_ff @(posedge clk_sys) begin
    if (rst) p_reg <= mrs_pkg::D_ZERO;
    else if (is_alu && store_field == mrs_pkg::S_P) p_reg <= alu_y;
    else if ((is_alu || wt == mrs_pkg::WT_SPEC) && spc == mrs_pkg::SPC_INCP) p_reg <= p_reg + mrs_pkg::D_ONE;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) q_reg <= mrs_pkg::D_ZERO;
    else if (load_low_word) q_reg <= alu_y;
    else if (is_alu && alu_dbl) q_reg <= alu_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) acc_reg <= mrs_pkg::D_ZERO;
    else if (wt == mrs_pkg::WT_IMM) acc_reg <= cs_word[mrs_pkg::IMM_HI:mrs_pkg::IMM_LO];
    else if (is_alu && store_field == mrs_pkg::S_ACC) acc_reg <= alu_y;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) zero_reg <= 1'b0;
    else if (is_alu) zero_reg <= (alu_y == mrs_pkg::D_ZERO);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) t_reg <= mrs_pkg::D_ZERO;
    else if (mem_ret_valid) t_reg <= mem_ret_data;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) sw_reg <= mrs_pkg::D_ZERO;
    else     sw_reg <= switches;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) n_reg <= '0;
    else if (is_alu && store_field == mrs_pkg::S_N) n_reg <= alu_y[mrs_pkg::IDX_W-1:0];
    else if ((is_alu || wt == mrs_pkg::WT_SPEC) && spc == mrs_pkg::SPC_INCN) n_reg <= n_reg + mrs_pkg::IDX_ONE;
    else if ((is_alu || wt == mrs_pkg::WT_SPEC) && spc == mrs_pkg::SPC_DECN) n_reg <= n_reg - mrs_pkg::IDX_ONE;
  end

  // indexed register files
  always_ff @(posedge clk_sys) begin
    if (is_alu && store_field == mrs_pkg::S_SCR) scr_mem[n_reg] <= alu_y;
    if (is_alu && store_field == mrs_pkg::S_PRV) prv_mem[n_reg] <= alu_y;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) map_address_pointer_reg <= '0;
    else if (map_address_pointer_wr) map_address_pointer_reg <= alu_y[mrs_pkg::MAP_ADDRESS_POINTER_W-1:0];
    else if (map_acc) map_address_pointer_reg <= map_address_pointer_reg + mrs_pkg::MAP_ADDRESS_POINTER_ONE;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pel_lo_reg <= mrs_pkg::D_ZERO;
      pel_hi_reg <= 8'h00;
    end else if (pe_strobe) begin
      pel_lo_reg <= pe_addr[15:0];
      pel_hi_reg <= pe_addr[23:16];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) cil_reg <= mrs_pkg::D_ZERO;
    else if (io_int_strobe) cil_reg <= io_trap_cell;
  end

  // pending interrupts; a new request wins over a clear in the same cycle
  always_comb begin
    iclr = '0;
    if ((is_alu || wt == mrs_pkg::WT_SPEC) && spc == mrs_pkg::SPC_INTCLR && int_pending)
      iclr[int_code - mrs_pkg::INT_IO] = 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) ipend_reg <= '0;
    else     ipend_reg <= (ipend_reg & ~iclr) | {int_internal, io_int_strobe};
  end

  always_comb begin
    int_code = mrs_pkg::INT_NONE;
    if (ipend_reg[0]) int_code = mrs_pkg::INT_IO;
    for (int i = 0; i < mrs_pkg::INT_N; i++) begin
      if (ipend_reg[i+1]) int_code = mrs_pkg::INT_BASE + 3'(i);
    end
  end

  // posted writes to the memory controller and the accessory
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      map_wr     <= 1'b0;
      map_waddr  <= '0;
      map_wdata  <= mrs_pkg::D_ZERO;
      fpa_wr     <= 1'b0;
      fpa_windex <= '0;
      fpa_wdata  <= mrs_pkg::D_ZERO;
    end else begin
      map_wr     <= is_alu && store_field == mrs_pkg::S_MAP;
      map_waddr  <= map_address_pointer_reg;
      map_wdata  <= alu_y;
      fpa_wr     <= is_alu && store_field == mrs_pkg::S_EXT && fpa_sel;
      fpa_windex <= n_reg;
      fpa_wdata  <= alu_y;
    end
  end

  assign cs_addr      = upc_reg;
  assign map_addr     = map_address_pointer_reg;
  assign map_rd       = is_alu && bsel == mrs_pkg::B_MAP;
  assign fpa_index    = n_reg;
  assign fpa_rd       = is_alu && bsel == mrs_pkg::B_EXT && fpa_sel;
  assign pc_out       = p_reg;
  assign acc_out      = acc_reg;
  assign low_word_out = q_reg;
  assign int_pending  = |ipend_reg;
  assign diag_mode    = sw_reg[mrs_pkg::SW_SELFTEST_LO];

  sequence s_call;
    wt == mrs_pkg::WT_JSB;
  endsequence
  sequence s_ret;
    wt == mrs_pkg::WT_RTN;
  endsequence

  property p_pc_inc;
    @(posedge clk_sys) disable iff (rst)
      (spc == mrs_pkg::SPC_INCP && (wt == mrs_pkg::WT_SPEC || (is_alu && store_field != mrs_pkg::S_P)))
      |=> p_reg == $past(p_reg) + mrs_pkg::D_ONE;
  endproperty
  a_pc_inc: assert property (p_pc_inc) else $error("pc did not increment");

  property p_ldq_only;
    @(posedge clk_sys) disable iff (rst) !(load_low_word || (is_alu && alu_dbl)) |=> $stable(q_reg);
  endproperty
  a_ldq_only: assert property (p_ldq_only) else $error("low word changed without load");

  property p_dshift;
    @(posedge clk_sys) disable iff (rst)
      (is_alu && aop == mrs_pkg::ALU_DSHL && !load_low_word) |=> q_reg == {$past(q_reg[14:0]), 1'b0};
  endproperty
  a_dshift: assert property (p_dshift) else $error("double shift low word wrong");

  property p_qmux;
    @(posedge clk_sys) disable iff (rst) bsel == mrs_pkg::B_Q |-> bmux == q_reg;
  endproperty
  a_qmux: assert property (p_qmux) else $error("low word not on alu input");

  property p_tret;
    @(posedge clk_sys) disable iff (rst) !mem_ret_valid |=> $stable(t_reg);
  endproperty
  a_tret: assert property (p_tret) else $error("return register loaded without data");

  property p_map_address_pointer_inc;
    @(posedge clk_sys) disable iff (rst)
      (map_acc && !map_address_pointer_wr) |=> map_address_pointer_reg == $past(map_address_pointer_reg) + mrs_pkg::MAP_ADDRESS_POINTER_ONE;
  endproperty
  a_map_address_pointer_inc: assert property (p_map_address_pointer_inc) else $error("map pointer did not advance");

  property p_pel;
    @(posedge clk_sys) disable iff (rst)
      pe_strobe |=> pel_lo_reg == $past(pe_addr[15:0]) && ext_rd_hi_ok;
  endproperty
  assign ext_rd_hi_ok = (n_reg != mrs_pkg::EXT_PEL_HI) || (ext_rd[15:8] == 8'h00);
  a_pel: assert property (p_pel) else $error("parity latch not updated");

  property p_call;
    @(posedge clk_sys) disable iff (rst) s_call |=> stk_top == $past(upc_reg) + mrs_pkg::UA_ONE;
  endproperty
  a_call: assert property (p_call) else $error("call pushed wrong address");

  property p_ret;
    @(posedge clk_sys) disable iff (rst) s_ret |=> upc_reg == $past(stk_top);
  endproperty
  a_ret: assert property (p_ret) else $error("return went to wrong address");

  property p_int_rank;
    @(posedge clk_sys) disable iff (rst)
      (|ipend_reg[mrs_pkg::INT_N:1]) |-> int_code >= mrs_pkg::INT_BASE;
  endproperty
  a_int_rank: assert property (p_int_rank) else $error("io interrupt ranked above internal");

endmodule

// ===== mrs_far_model.sv
// far-side model: control store, map RAM and floating-point accessory registers
// assumes combinational reads and writes taken on the edge that samples each strobe
`timescale 1ns/1ns
module mrs_far_model (
  input  wire logic        clk_sys,
  input  wire logic [13:0] cs_addr,
  output logic [31:0]      cs_word,
  input  wire logic [9:0]  map_addr,
  input  wire logic        map_rd,
  output logic [15:0]      map_rdata,
  input  wire logic        map_wr,
  input  wire logic [9:0]  map_waddr,
  input  wire logic [15:0] map_wdata,
  input  wire logic [3:0]  fpa_index,
  input  wire logic        fpa_rd,
  output logic [15:0]      fpa_rdata,
  input  wire logic        fpa_wr,
  input  wire logic [3:0]  fpa_windex,
  input  wire logic [15:0] fpa_wdata
);
  logic [31:0] cs_mem  [0:16383];
  logic [15:0] map_mem [0:1023];
  logic [15:0] fpa_mem [0:15];

  assign cs_word = cs_mem[cs_addr];
  // unselected data lines show the inverse so a stale value never passes
  assign map_rdata = map_rd ? map_mem[map_addr] : ~map_mem[map_addr];
  assign fpa_rdata = fpa_rd ? fpa_mem[fpa_index] : ~fpa_mem[fpa_index];

  always_ff @(posedge clk_sys) begin
    if (map_wr) begin
      map_mem[map_waddr] <= map_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (fpa_wr) begin
      fpa_mem[fpa_windex] <= fpa_wdata;
    end
  end
endmodule

// ===== tb.sv
// self-checking bench: loads short microprograms into the far model and checks results
// assumes the register set and far model; one 125 MHz clock, synchronous reset
`timescale 1ns/1ns
module tb;
  logic        clk_sys       = 1'b0;
  logic        rst           = 1'b1;
  logic [15:0] switches      = 16'h0000;
  logic        mem_ret_valid = 1'b0;
  logic [15:0] mem_ret_data  = 16'h0000;
  logic        pe_strobe     = 1'b0;
  logic [23:0] pe_addr       = 24'h000000;
  logic        io_int_strobe = 1'b0;
  logic [15:0] io_trap_cell  = 16'h0000;
  logic [3:0]  int_internal  = 4'h0;
  logic [13:0] cs_addr;
  logic [31:0] cs_word;
  logic [9:0]  map_addr, map_waddr;
  logic        map_rd, map_wr, fpa_rd, fpa_wr, int_pending, diag_mode;
  logic [15:0] map_rdata, map_wdata, fpa_rdata, fpa_wdata, pc_out, acc_out, low_word_out;
  logic [3:0]  fpa_index, fpa_windex;
  logic [2:0]  int_code;
  logic [15:0] ra, rb;
  logic [3:0]  k, c, r, ints, lo;
  int          miscompares  = 0;
  int          total_checks = 0;
  int          n;
  int          seed;

  always #4 clk_sys = ~clk_sys;

  mrs_register_set dut (
    .clk_sys(clk_sys), .rst(rst), .cs_addr(cs_addr), .cs_word(cs_word), .switches(switches),
    .mem_ret_valid(mem_ret_valid), .mem_ret_data(mem_ret_data), .pe_strobe(pe_strobe), .pe_addr(pe_addr),
    .io_int_strobe(io_int_strobe), .io_trap_cell(io_trap_cell), .int_internal(int_internal),
    .map_addr(map_addr), .map_rd(map_rd), .map_rdata(map_rdata), .map_wr(map_wr), .map_waddr(map_waddr),
    .map_wdata(map_wdata), .fpa_index(fpa_index), .fpa_rd(fpa_rd), .fpa_rdata(fpa_rdata), .fpa_wr(fpa_wr),
    .fpa_windex(fpa_windex), .fpa_wdata(fpa_wdata), .pc_out(pc_out), .acc_out(acc_out),
    .low_word_out(low_word_out), .int_pending(int_pending), .int_code(int_code), .diag_mode(diag_mode)
  );

  mrs_far_model far (
    .clk_sys(clk_sys), .cs_addr(cs_addr), .cs_word(cs_word), .map_addr(map_addr), .map_rd(map_rd),
    .map_rdata(map_rdata), .map_wr(map_wr), .map_waddr(map_waddr), .map_wdata(map_wdata),
    .fpa_index(fpa_index), .fpa_rd(fpa_rd), .fpa_rdata(fpa_rdata), .fpa_wr(fpa_wr),
    .fpa_windex(fpa_windex), .fpa_wdata(fpa_wdata)
  );

  function automatic logic [31:0] a(input logic [4:0] b, input logic [4:0] st,
                                    input logic [3:0] op = mrs_pkg::ALU_PASS,
                                    input logic [3:0] spc = mrs_pkg::SPC_NONE);
    return {mrs_pkg::WT_ALU, spc, b, st, op, 10'h000};
  endfunction

  function automatic logic [31:0] im(input logic [15:0] v);
    return {mrs_pkg::WT_IMM, 12'h000, v};
  endfunction

  function automatic logic [31:0] sp(input logic [3:0] spc);
    return {mrs_pkg::WT_SPEC, spc, 24'h000000};
  endfunction

  function automatic logic [31:0] jp(input logic [3:0] wt, input logic [13:0] ad);
    return {wt, ad, 14'h0000};
  endfunction

  // highest pending source wins, internal sources above the I/O source
  function automatic logic [2:0] icode(input logic [3:0] b, input logic io);
    for (int i = 3; i >= 0; i--) begin
      if (b[i]) return 3'(mrs_pkg::INT_BASE + 3'(i));
    end
    return io ? mrs_pkg::INT_IO : mrs_pkg::INT_NONE;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic put(input logic [31:0] w);
    far.cs_mem[n] = w;
    n++;
  endtask

  // closes the program with a self loop, resets, releases with event pulses, then runs
  task automatic go();
    put(jp(mrs_pkg::WT_JMP, 14'(n - 1)));
    far.cs_mem[n - 1] = jp(mrs_pkg::WT_JMP, 14'(n - 1));
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    pe_strobe = 1'b1;
    io_int_strobe = 1'b1;
    mem_ret_valid = 1'b1;
    int_internal = ints;
    @(posedge clk_sys);
    #1;
    pe_strobe = 1'b0;
    io_int_strobe = 1'b0;
    mem_ret_valid = 1'b0;
    int_internal = 4'h0;
    repeat (24) @(posedge clk_sys);
    #1;
    n = 0;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(4000 * 8);
    miscompares++;
    end_of_test();
  end

  initial begin
    seed = $urandom(90);
    n = 0;
    repeat (6) @(posedge clk_sys);
    #1;
    for (int it = 0; it < 5; it++) begin
      ra = (it == 0) ? 16'hFFFF : 16'($urandom);
      rb = 16'($urandom);
      k = (it == 0) ? 4'hF : 4'($urandom);
      c = (it == 0) ? 4'hF : 4'($urandom_range(15, 12));
      r = (it == 0) ? 4'h4 : 4'($urandom_range(11, 4));
      ints = (it == 0) ? 4'hF : 4'($urandom_range(15, 1));
      switches = 16'($urandom);
      pe_addr = 24'($urandom);
      io_trap_cell = 16'($urandom);
      mem_ret_data = 16'($urandom);
      put(im(ra)); put(a(mrs_pkg::B_ACC, mrs_pkg::S_P)); put(sp(mrs_pkg::SPC_INCP)); put(im(rb));
      put(a(mrs_pkg::B_ACC, mrs_pkg::S_NONE, mrs_pkg::ALU_PASS, mrs_pkg::SPC_ZERO));
      put(a(mrs_pkg::B_SW, mrs_pkg::S_ACC));
      put(a(mrs_pkg::B_Q, mrs_pkg::S_ACC, mrs_pkg::ALU_ADD, mrs_pkg::SPC_ONE));
      go();
      chk("program counter", pc_out, 16'(ra + 16'h0001));
      chk("accumulator sum", acc_out, 16'(switches + rb));
      chk("low word", low_word_out, 16'(switches + rb));
      chk("diag mode", diag_mode, switches[mrs_pkg::SW_SELFTEST_LO]);
      put(im(ra)); put(a(mrs_pkg::B_ACC, mrs_pkg::S_NONE, mrs_pkg::ALU_PASS, mrs_pkg::SPC_ZERO));
      put(im(rb)); put(a(mrs_pkg::B_ACC, mrs_pkg::S_ACC, mrs_pkg::ALU_DSHL));
      go();
      chk("shift high", acc_out, {rb[14:0], ra[15]});
      chk("shift low", low_word_out, {ra[14:0], 1'b0});
      put(im({12'h000, k})); put(a(mrs_pkg::B_ACC, mrs_pkg::S_N)); put(im(ra));
      put(a(mrs_pkg::B_ACC, mrs_pkg::S_SCR)); put(im(rb)); put(a(mrs_pkg::B_ACC, mrs_pkg::S_PRV));
      put(a(mrs_pkg::B_SCR, mrs_pkg::S_ACC)); put(a(mrs_pkg::B_PRV, mrs_pkg::S_ACC, mrs_pkg::ALU_ADD));
      go();
      chk("file sum", acc_out, 16'(ra + rb));
      put(im(16'h0000)); put(a(mrs_pkg::B_ACC, mrs_pkg::S_N)); put(im(ra));
      put(a(mrs_pkg::B_ACC, mrs_pkg::S_EXT)); put(a(mrs_pkg::B_ACC, mrs_pkg::S_MAP));
      put(a(mrs_pkg::B_MAP, mrs_pkg::S_NONE)); put(a(mrs_pkg::B_EXT, mrs_pkg::S_P));
      put(im({12'h000, c})); put(a(mrs_pkg::B_ACC, mrs_pkg::S_N)); put(a(mrs_pkg::B_ACC, mrs_pkg::S_EXT));
      put(im({12'h000, r})); put(a(mrs_pkg::B_ACC, mrs_pkg::S_N)); put(a(mrs_pkg::B_ACC, mrs_pkg::S_EXT));
      put(a(mrs_pkg::B_EXT, mrs_pkg::S_ACC));
      go();
      chk("map pointer", pc_out, {6'h00, 10'(ra[9:0] + 10'h002)});
      chk("map data", far.map_mem[ra[9:0]], ra);
      chk("accessory data", far.fpa_mem[c], {12'h000, c});
      chk("reserved read", acc_out, 16'h0000);
      put(im(16'h0001)); put(a(mrs_pkg::B_ACC, mrs_pkg::S_N)); put(a(mrs_pkg::B_EXT, mrs_pkg::S_P));
      put(sp(mrs_pkg::SPC_INCN)); put(a(mrs_pkg::B_EXT, mrs_pkg::S_ACC)); put(sp(mrs_pkg::SPC_INCN));
      put(a(mrs_pkg::B_EXT, mrs_pkg::S_NONE, mrs_pkg::ALU_PASS, mrs_pkg::SPC_ZERO));
      go();
      chk("parity low", pc_out, pe_addr[15:0]);
      chk("parity high", acc_out, {8'h00, pe_addr[23:16]});
      chk("trap cell", low_word_out, io_trap_cell);
      put(jp(mrs_pkg::WT_JSB, 14'h0004)); put(a(mrs_pkg::B_T, mrs_pkg::S_P));
      put(a(mrs_pkg::B_ACC, mrs_pkg::S_ACC, mrs_pkg::ALU_INC)); put(jp(mrs_pkg::WT_JMP, 14'h0003));
      put(a(mrs_pkg::B_ACC, mrs_pkg::S_ACC, mrs_pkg::ALU_INC)); put(jp(mrs_pkg::WT_RTN, 14'h0000));
      go();
      chk("return path", acc_out, 16'h0002);
      chk("returned data", pc_out, mem_ret_data);
      chk("pending", int_pending, 1'b1);
      chk("int code", int_code, icode(ints, 1'b1));
      put(im(ra)); put(a(mrs_pkg::B_ACC, mrs_pkg::S_NONE, mrs_pkg::ALU_XOR)); put(jp(mrs_pkg::WT_JNZ, 14'h0004));
      put(jp(mrs_pkg::WT_JZ, 14'h0005)); put(sp(mrs_pkg::SPC_DECN)); put(jp(mrs_pkg::WT_JINT, 14'h0007));
      put(sp(mrs_pkg::SPC_DECN)); put(jp(mrs_pkg::WT_JSW, 14'h0009)); put(sp(mrs_pkg::SPC_DECN));
      put(a(mrs_pkg::B_INT, mrs_pkg::S_P));
      put(a(mrs_pkg::B_N, mrs_pkg::S_NONE, mrs_pkg::ALU_PASS, mrs_pkg::SPC_ZERO));
      put(a(mrs_pkg::B_ACC, mrs_pkg::S_ACC, mrs_pkg::ALU_DSHR));
      go();
      chk("branch int code", pc_out, {13'h0000, icode(ints, 1'b1)});
      chk("shift right high", acc_out, {1'b0, ra[15:1]});
      chk("branch index", low_word_out, {ra[0], 12'h000, switches[mrs_pkg::SW_SELFTEST_LO] ? 3'h0 : 3'h7});
      lo = ints;
      for (int i = 3; i >= 0; i--) begin
        if (lo[i]) begin
          lo[i] = 1'b0;
          break;
        end
      end
      put(sp(mrs_pkg::SPC_NONE)); put(sp(mrs_pkg::SPC_INTCLR));
      go();
      chk("int code after clear", int_code, icode(lo, 1'b1));
    end
    end_of_test();
  end
endmodule
